/* rtl/lvdc_consts.vh */
`ifndef LVDC_CONSTS_VH
`define LVDC_CONSTS_VH

// ****************************************
// Register addresses on the internal bus
// ****************************************
`define LVDC_ADDR_W        16
`define LVDC_CTRL_ADDR     16'hFFBE
`define LVDC_THR_ADDR      16'hFFBF
`define LVDC_CAUSE_ADDR    16'hFFA8

// ****************************************
// Field positions
// ****************************************
`define LVDC_ENABLE_BIT    7
`define LVDC_SOURCE_BIT    2
`define LVDC_MODE_BIT      1
`define LVDC_FLAG_BIT      0
`define LVDC_CAUSE_BIT     0
`define LVDC_THR_MSB       3

// ****************************************
// Reset values
// ****************************************
`define LVDC_CTRL_RESET    8'h00
`define LVDC_THR_RESET     4'h0
`define LVDC_READ_ZERO     8'h00

// ****************************************
// Timing
// ****************************************
`define LVDC_CLK_MHZ       20
`define LVDC_STAB_US       10
`define LVDC_PULSE_US      200
`define LVDC_STAB_CYC      (`LVDC_STAB_US * `LVDC_CLK_MHZ)
`define LVDC_PULSE_CYC     (`LVDC_PULSE_US * `LVDC_CLK_MHZ)

`endif

/* rtl/lvdc_sync.v */
`timescale 1ns/1ps

// Two-stage synchroniser for comparator levels that change with no regard to clk
module lvdc_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // Only the second stage reads the first
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // lvdc_sync

/* rtl/lvdc_top.v */
// Overview of operation
// - Compare supply or pin; request reset/interrupt
// - Control bit 2 selects supply or pin
// - Control bit 1: interrupt or reset response
// - Interrupt on both falling and recovering level
// - Reset request held while level below threshold
// - Bit 0 read-only below-level flag
// - Supervisor reset sets reset-cause bit 0
// - Bit 7 enables comparator and detection
// - Only outside resets clear the control bits
// - Below level must persist minimum pulse width
// - Disabling while below raises an interrupt
// - Sixteen selectable supply thresholds
// - Keeps working during stop mode
// - Four-bit threshold field, frozen while running

`include "lvdc_consts.vh"
`timescale 1ns/1ps

module lvdc_top #(
  parameter STAB_CYC  = `LVDC_STAB_CYC,
  parameter PULSE_CYC = `LVDC_PULSE_CYC,
  parameter CNT_W     = 12
) (
  // Clock and reset (outside resets only, never the supervisor's own)
  input  wire                    clk,
  input  wire                    arst_n,
  // Internal CPU bus
  input  wire [`LVDC_ADDR_W-1:0] bus_addr,
  input  wire                    bus_wr,
  input  wire                    bus_rd,
  input  wire [7:0]              bus_wdata,
  output reg  [7:0]              bus_rdata,
  // Analog comparator side
  input  wire                    cmp_supply_below,
  input  wire                    cmp_ext_below,
  output reg                     detect_enable,
  output reg                     source_select,
  output reg  [3:0]              threshold_sel,
  // System side
  output reg                     supervisor_reset_req,
  output reg                     detect_irq,
  output reg                     supervisor_reset_cause
);

  // ****************************************
  // Constants and decode
  // ****************************************
  // Terminal counts are cut to CNT_W on purpose; CNT_W must be wide enough to hold them
  localparam integer     STAB_LAST_I  = STAB_CYC - 1;
  localparam integer     PULSE_LAST_I = PULSE_CYC - 1;
  localparam [CNT_W-1:0] STAB_LAST    = STAB_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] PULSE_LAST   = PULSE_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE      = {{(CNT_W-1){1'b0}}, 1'b1};

  function hit;
    input [`LVDC_ADDR_W-1:0] addr;
    input [`LVDC_ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  wire wr_ctrl  = bus_wr && hit(bus_addr, `LVDC_CTRL_ADDR);
  wire wr_thr   = bus_wr && hit(bus_addr, `LVDC_THR_ADDR);
  wire rd_cause = bus_rd && hit(bus_addr, `LVDC_CAUSE_ADDR);

  // ****************************************
  // Control state
  // ****************************************
  reg             reset_or_irq_select;
  reg             below_level_flag;
  reg             flag_q;
  reg             stab_done;
  reg [CNT_W-1:0] stab_cnt;
  reg [CNT_W-1:0] pulse_cnt;
  wire [1:0]      below_sync;

  // Bit 1 carries the external pin, bit 0 the supply
  // comparator synchronisation
  lvdc_sync #(
    .WIDTH    (2)
  ) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({cmp_ext_below, cmp_supply_below}),
    .sync_out (below_sync)
  );

  wire below_sel = source_select ? below_sync[1] : below_sync[0];

  // The supervisor's own reset request never reaches arst_n, so these bits survive it
  // cleared by outside resets only
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      detect_enable       <= 1'b0;
      source_select       <= 1'b0;
      reset_or_irq_select <= 1'b0;
    end else if (wr_ctrl) begin
      detect_enable       <= bus_wdata[`LVDC_ENABLE_BIT];
      source_select       <= bus_wdata[`LVDC_SOURCE_BIT];
      reset_or_irq_select <= bus_wdata[`LVDC_MODE_BIT];
    end
  end

  // Writes while running are dropped so the level never moves under the comparator
  // sixteen threshold levels
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      threshold_sel <= `LVDC_THR_RESET;
    end else if (wr_thr && !detect_enable) begin
      threshold_sel <= bus_wdata[`LVDC_THR_MSB:0];
    end
  end

  // ****************************************
  // Stabilisation and pulse-width filter
  // ****************************************
  // The comparator output is ignored until it has settled, so a
  // glitch straight after enabling cannot start the width count.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stab_cnt  <= {CNT_W{1'b0}};
      stab_done <= 1'b0;
    end else if (!detect_enable) begin
      stab_cnt  <= {CNT_W{1'b0}};
      stab_done <= 1'b0;
    end else if (!stab_done) begin
      if (stab_cnt == STAB_LAST) begin
        stab_done <= 1'b1;
      end else begin
        stab_cnt <= stab_cnt + CNT_ONE;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_cnt        <= {CNT_W{1'b0}};
      below_level_flag <= 1'b0;
    // flag clears on recovery or disable
    end else if (!detect_enable || !stab_done || !below_sel) begin
      pulse_cnt        <= {CNT_W{1'b0}};
      below_level_flag <= 1'b0;
    end else if (!below_level_flag) begin
      if (pulse_cnt == PULSE_LAST) begin
        below_level_flag <= 1'b1;
      end else begin
        pulse_cnt <= pulse_cnt + CNT_ONE;
      end
    end
  end

  // ****************************************
  // Responses
  // ****************************************
  // Edges of the filtered flag, not of the raw comparator, raise the interrupt
  // no clock gating, so stop mode keeps detection alive
  wire flag_change = below_level_flag ^ flag_q;
  // Cause sets as the reset request rises; a set in the same cycle as a read wins
  // over the read clear, so no supervisor reset goes unreported
  wire next_cause  = (reset_or_irq_select && below_level_flag && !supervisor_reset_req) ||
                     (supervisor_reset_cause && !rd_cause);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q                 <= 1'b0;
      detect_irq             <= 1'b0;
      supervisor_reset_req   <= 1'b0;
      supervisor_reset_cause <= 1'b0;
    end else begin
      flag_q                 <= below_level_flag;
      // pulse on either edge, incl. disable
      detect_irq             <= flag_change && !reset_or_irq_select;
      supervisor_reset_req   <= reset_or_irq_select && below_level_flag;
      // reset cause, set wins over read clear
      supervisor_reset_cause <= next_cause;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Registered so the read data comes straight from a flip-flop
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = `LVDC_READ_ZERO;
    if (bus_rd) begin
      if (hit(bus_addr, `LVDC_CTRL_ADDR)) begin
        next_rdata[`LVDC_ENABLE_BIT] = detect_enable;
        next_rdata[`LVDC_SOURCE_BIT] = source_select;
        next_rdata[`LVDC_MODE_BIT]   = reset_or_irq_select;
        next_rdata[`LVDC_FLAG_BIT]   = below_level_flag;
      end else if (hit(bus_addr, `LVDC_THR_ADDR)) begin
        next_rdata[`LVDC_THR_MSB:0] = threshold_sel;
      end else if (rd_cause) begin
        next_rdata[`LVDC_CAUSE_BIT] = supervisor_reset_cause;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= `LVDC_READ_ZERO;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

endmodule // lvdc_top

/* sim/lvdc_chk.sv */
`timescale 1ns/1ps
// ********************
// Supervisor checker
// ********************
module lvdc_chk #(
  parameter STAB_CYC  = 200,
  parameter PULSE_CYC = 4000,
  parameter CNT_W     = 12
) (
  // Clock and reset
  input wire        clk,
  input wire        arst_n,
  // Register bus
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [15:0] bus_addr,
  input wire [7:0]  bus_wdata,
  input wire [7:0]  bus_rdata,
  // Comparator side
  input wire        cmp_supply_below,
  input wire        cmp_ext_below,
  input wire        detect_enable,
  input wire        source_select,
  input wire [3:0]  threshold_sel,
  // System side
  input wire        supervisor_reset_req,
  input wire        detect_irq,
  input wire        supervisor_reset_cause
);
  // Raw below-level run length, saturating; as wide as the design's width counter
  reg [CNT_W-1:0] run;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) run <= {CNT_W{1'b0}};
    else if (!(source_select ? cmp_ext_below : cmp_supply_below)) run <= {CNT_W{1'b0}};
    else if (run != {CNT_W{1'b1}}) run <= run + {{(CNT_W-1){1'b0}}, 1'b1};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_ctrl_read: assert property ($past(bus_rd && bus_addr == 16'hFFBE) |-> bus_rdata[6:3] == 4'h0
    && bus_rdata[7] == $past(detect_enable) && bus_rdata[2] == $past(source_select)) else $error("ctrl read bad");
  chk_irq_pulse: assert property (detect_irq |=> !detect_irq) else $error("irq too long");
  chk_req_enable: assert property (supervisor_reset_req |->
    $past(detect_enable, 2) || $past(detect_enable, 3)) else $error("req without enable");
  chk_irq_enable: assert property (detect_irq |->
    $past(detect_enable, 2) || $past(detect_enable, 3)) else $error("irq without enable");
  chk_cause_set: assert property ($rose(supervisor_reset_req) |-> ##[0:1] supervisor_reset_cause)
    else $error("cause not set");
  chk_cause_read: assert property ($past(bus_rd && bus_addr == 16'hFFA8) |->
    bus_rdata[0] == $past(supervisor_reset_cause)) else $error("cause read bad");
  chk_thr_frozen: assert property ($past(detect_enable) |-> $stable(threshold_sel))
    else $error("threshold moved");
  chk_ctrl_write: assert property ($past(bus_wr && bus_addr == 16'hFFBE) |->
    detect_enable == $past(bus_wdata[7]) && source_select == $past(bus_wdata[2])) else $error("ctrl write bad");
  chk_min_width: assert property ($rose(supervisor_reset_req) |-> $past(run, 4) >= PULSE_CYC - 1)
    else $error("filter too short");
endmodule // lvdc_chk

bind lvdc_top lvdc_chk #(
  .STAB_CYC               (STAB_CYC),
  .PULSE_CYC              (PULSE_CYC),
  .CNT_W                  (CNT_W)
) chk_u (
  .clk                    (clk),
  .arst_n                 (arst_n),
  .bus_wr                 (bus_wr),
  .bus_rd                 (bus_rd),
  .bus_addr               (bus_addr),
  .bus_wdata              (bus_wdata),
  .bus_rdata              (bus_rdata),
  .cmp_supply_below       (cmp_supply_below),
  .cmp_ext_below          (cmp_ext_below),
  .detect_enable          (detect_enable),
  .source_select          (source_select),
  .threshold_sel          (threshold_sel),
  .supervisor_reset_req   (supervisor_reset_req),
  .detect_irq             (detect_irq),
  .supervisor_reset_cause (supervisor_reset_cause)
);

/* sim/test_lvdc_top.sv */
`timescale 1ns/1ps
// ********************
// Supervisor bench
// ********************
module test_lvdc_top;
  localparam [7:0] STAB  = 8'h04;
  localparam [7:0] PULSE = 8'h08;
  reg        clk = 1'b0, arst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  reg        cmp_supply_below = 1'b0, cmp_ext_below = 1'b0;
  reg [15:0] bus_addr = 16'h0000;
  reg [7:0]  bus_wdata = 8'h00, rdv;
  wire [7:0] bus_rdata;
  wire [3:0] threshold_sel;
  wire       detect_enable, source_select, supervisor_reset_req, detect_irq, supervisor_reset_cause;
  integer    failures = 0, check_count = 0, i, n;
  lvdc_top #(
    .STAB_CYC               (STAB),
    .PULSE_CYC              (PULSE),
    .CNT_W                  (12)
  ) dut_u (
    .clk                    (clk),
    .arst_n                 (arst_n),
    .bus_addr               (bus_addr),
    .bus_wr                 (bus_wr),
    .bus_rd                 (bus_rd),
    .bus_wdata              (bus_wdata),
    .bus_rdata              (bus_rdata),
    .cmp_supply_below       (cmp_supply_below),
    .cmp_ext_below          (cmp_ext_below),
    .detect_enable          (detect_enable),
    .source_select          (source_select),
    .threshold_sel          (threshold_sel),
    .supervisor_reset_req   (supervisor_reset_req),
    .detect_irq             (detect_irq),
    .supervisor_reset_cause (supervisor_reset_cause)
  );
  initial forever #25 clk = ~clk;
  task give_verdict; begin
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end endtask
  task chk(input [8*10:1] nm, input [7:0] seen, input [7:0] exp); begin
    check_count = check_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR %0s exp %h seen %h", nm, exp, seen);
    end
  end endtask
  task wr(input [15:0] a, input [7:0] d); begin
    @(posedge clk); bus_addr <= a; bus_wdata <= d; bus_wr <= 1'b1;
    @(posedge clk); bus_wr <= 1'b0;
  end endtask
  task rc(input [15:0] a, input [7:0] e); begin
    @(posedge clk); bus_addr <= a; bus_rd <= 1'b1;
    @(posedge clk); bus_rd <= 1'b0;
    // Read data stands for the cycle after the read edge
    @(posedge clk); rdv = bus_rdata;
    chk("reg read", rdv, e);
  end endtask
  // Bounded wait: 0 irq, 1 request high, 2 request low; n counts cycles
  task wait_for(input [1:0] s); begin
    n = 0;
    while ((s == 0 ? detect_irq : s == 1 ? supervisor_reset_req : !supervisor_reset_req) !== 1'b1) begin
      @(posedge clk); n = n + 1;
      if (n > 60) begin failures = failures + 1; $display("ERROR wait exp 1 seen 0"); give_verdict; end
    end
  end endtask
  task t_regs; begin
    rc(16'hFFBE, 8'h00);
    wr(16'hFFBE, 8'h7F); rc(16'hFFBE, 8'h06);
    for (i = 0; i < 16; i = i + 1) begin
      wr(16'hFFBF, i[7:0] | 8'hF0); rc(16'hFFBF, i[7:0]); chk("thr out", {4'h0, threshold_sel}, i[7:0]);
    end
    wr(16'hFFBE, 8'h80); wr(16'hFFBF, 8'h03); rc(16'hFFBF, 8'h0F);
    rc(16'h1234, 8'h00);
    wr(16'hFFBE, 8'h00);
    $display("t_regs done");
  end endtask
  task t_irq; begin
    wr(16'hFFBE, 8'h84); repeat (STAB + 4) @(posedge clk);
    chk("ctrl out", {6'h00, detect_enable, source_select}, 8'h03);
    cmp_supply_below <= 1'b1; repeat (PULSE + 6) @(posedge clk); rc(16'hFFBE, 8'h84);
    cmp_ext_below <= 1'b1; wait_for(0); chk("min width", n[7:0], PULSE + 8'h04);
    rc(16'hFFBE, 8'h85);
    cmp_ext_below <= 1'b0; wait_for(0); rc(16'hFFBE, 8'h84);
    cmp_ext_below <= 1'b1; wait_for(0); wr(16'hFFBE, 8'h00); wait_for(0); chk("irq off", n[7:0], 8'h03);
    cmp_supply_below <= 1'b0; cmp_ext_below <= 1'b0;
    $display("t_irq done");
  end endtask
  task t_rst; begin
    wr(16'hFFBE, 8'h80); repeat (STAB + 4) @(posedge clk);
    wr(16'hFFBE, 8'h82); cmp_supply_below <= 1'b1; wait_for(1);
    chk("cause out", supervisor_reset_cause, 8'h01);
    rc(16'hFFA8, 8'h01); rc(16'hFFA8, 8'h00);
    rc(16'hFFBE, 8'h83); chk("req held", supervisor_reset_req, 1);
    cmp_supply_below <= 1'b0; wait_for(2); rc(16'hFFBE, 8'h82);
    arst_n <= 1'b0; @(posedge clk); arst_n <= 1'b1; rc(16'hFFBE, 8'h00);
    $display("t_rst done");
  end endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_irq;
    t_rst;
    give_verdict;
  end
endmodule // test_lvdc_top
